// ---- common/itc_consts.svh ----
// Register indices, field positions, reset values and sizes of the identity/FIFO register slice
//
// Contract
// - 24-bit read turnaround, three writable bytes, reset zero
// - Turnaround bytes live only with speed-limit option
// - 15-bit maker identity split over bytes six/five
// - Identity type selector bit reads zero
// - 16-bit part identity in bytes four/three
// - Instance and 12-bit extra identity in bytes two/one
// - Writable 7-bit fixed address, option-dependent reset
// - Capability one bit0 equals HDR build option
// - Capability two bits 7:6 equal HDR option
// - Group bits zero, minor version never zero
// - Capability three bit6 equals pending-read option
// - Oscillator tolerance byte writable, tenth-percent steps
// - Receive port read pops oldest byte
// - Transmit port write appends one byte
// - Transmit port read returns empty flag only
// - Soft reset bit4 resets writable registers only
// - Soft reset bit3 resets engine and FIFOs
// - Bit2 flushes transmit, bit1 flushes receive
// - Soft reset bit0 resets entire core
// - Each FIFO holds 512 bytes
`ifndef ITC_CONSTS_SVH
`define ITC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ITC_IDX_RDT_HI 6'h0E
`define ITC_IDX_RDT_MID 6'h0F
`define ITC_IDX_RDT_LO 6'h10
`define ITC_IDX_ID6 6'h11
`define ITC_IDX_ID5 6'h12
`define ITC_IDX_ID4 6'h13
`define ITC_IDX_ID3 6'h14
`define ITC_IDX_ID2 6'h15
`define ITC_IDX_ID1 6'h16
`define ITC_IDX_FBA 6'h17
`define ITC_IDX_CAP1 6'h18
`define ITC_IDX_CAP2 6'h19
`define ITC_IDX_CAP3 6'h1A
`define ITC_IDX_OSC 6'h1C
`define ITC_IDX_RXQ 6'h20
`define ITC_IDX_TXQ 6'h22
`define ITC_IDX_SRST 6'h28

// ----------------------------------------------------------------
// Soft reset bit positions
// ----------------------------------------------------------------
`define ITC_SRST_WHOLE 0
`define ITC_SRST_RXQ 1
`define ITC_SRST_TXQ 2
`define ITC_SRST_ENGINE 3
`define ITC_SRST_REGS 4

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define ITC_FBA_RST 7'h08
`define ITC_FIFO_DEPTH 10'h200
`define ITC_FIFO_AW 9

`endif

// ---- common/itc_pkg.sv ----
// Types shared by the identity/capability/FIFO register slice
package itc_pkg;

  // Software-writable configuration handed to the protocol engine
  typedef struct packed {
    logic [7:0] rdt_hi;
    logic [7:0] rdt_mid;
    logic [7:0] rdt_lo;
    logic [14:0] maker_id;
    logic [15:0] part_id;
    logic [3:0] inst_id;
    logic [11:0] extra_id;
    logic [6:0] fixed_addr;
    logic [7:0] osc_tol;
  } itc_cfg_t;

  // Bus slave phase
  typedef enum logic [1:0] {
    ITC_ST_IDLE = 2'b01,
    ITC_ST_ACK = 2'b10
  } itc_apb_st_t;

endpackage

// ---- design/itc_regbank.sv ----
// Identity, capability, FIFO port and soft reset registers behind an APB slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "itc_consts.svh"

module itc_regbank import itc_pkg::*; #(
  parameter bit HDR_CAP = 1'b0,
  parameter bit IBI_MDB_CAP = 1'b0,
  parameter bit MAX_DS_LIMIT = 1'b1,
  parameter bit FBA_EN = 1'b1,
  // Identity reset values: arbitrary neutral defaults
  parameter logic [14:0] MAKER_ID_RST = 15'h0155,
  parameter logic [15:0] PART_ID_RST = 16'h00A5,
  parameter logic [3:0] INST_ID_RST = 4'h2,
  parameter logic [11:0] EXTRA_ID_RST = 12'h000,
  // Minor specification version, must not be zero; arbitrary default
  parameter logic [3:0] SPEC_MINOR = 4'h2
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Protocol engine side (asynchronous to the core clock)
  input wire logic i_link_clk,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_tx_take,
  // Queue state and head byte towards the engine
  output logic [7:0] o_tx_data,
  output logic o_tx_avail,
  output logic o_tx_full,
  output logic o_rx_not_empty,
  output logic o_rx_full,
  // Configuration and reset requests towards the engine
  output itc_cfg_t o_cfg,
  output logic o_engine_rst,
  output logic o_whole_rst
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Register select from the word address
  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // Reset image of the writable registers
  function automatic itc_cfg_t cfg_rst();
    itc_cfg_t c;
    c = '0;
    c.maker_id = MAKER_ID_RST;
    c.part_id = PART_ID_RST;
    c.inst_id = INST_ID_RST;
    c.extra_id = EXTRA_ID_RST;
    c.fixed_addr = FBA_EN ? `ITC_FBA_RST : 7'h00;
    cfg_rst = c;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  itc_apb_st_t st_ff; // Bus phase
  logic [31:0] nxt_prdata; // Read mux
  logic nxt_err; // Unmapped access
  logic acc; // Transfer completes this edge
  logic wr_acc; // Completing write
  logic rd_acc; // Completing read
  itc_cfg_t cfg_ff; // Writable registers
  logic [4:0] srst_ff; // Self-clearing reset pulses
  logic regs_clr; // Writable register reset
  logic rx_clr; // Receive queue flush
  logic tx_clr; // Transmit queue flush
  logic lclk_s1_ff, lclk_s2_ff, lclk_s3_ff; // Link clock sampler
  logic rxv_s1_ff, rxv_s2_ff; // Receive strobe sampler
  logic [7:0] rxd_s1_ff, rxd_s2_ff; // Receive byte sampler
  logic take_s1_ff, take_s2_ff; // Take strobe sampler
  logic link_edge; // Rising link clock edge
  logic [7:0] rx_mem [0:511]; // Receive storage
  logic [7:0] tx_mem [0:511]; // Transmit storage
  logic [`ITC_FIFO_AW-1:0] rx_wr_ff, rx_rd_ff, tx_wr_ff, tx_rd_ff; // Queue pointers
  logic [9:0] rx_cnt_ff, tx_cnt_ff; // Queue fill levels
  logic rx_push, rx_pop, tx_push, tx_pop; // Queue moves
  logic [7:0] cap1, cap2, cap3; // Build-fixed capability bytes

  // ----------------------------------------------------------------
  // Capability bytes
  // ----------------------------------------------------------------
  // Other HDR modes never offered, only DDR follows the build option
  assign cap1 = {7'h00, HDR_CAP};
  // Abort capabilities track HDR; group address bits stay zero
  assign cap2 = {HDR_CAP, HDR_CAP, 2'h0, SPEC_MINOR};
  // Only the pending-read notification may be advertised
  assign cap3 = {1'b0, IBI_MDB_CAP, 6'h00};

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: ready is raised in the second access cycle, so
  // read data and side effects are settled from flops.
  assign acc = (st_ff == ITC_ST_ACK);
  assign wr_acc = acc && i_pwrite;
  assign rd_acc = acc && !i_pwrite;

  // Read mux and address decode
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (hit(i_paddr, `ITC_IDX_RDT_HI)) begin
      nxt_prdata[7:0] = MAX_DS_LIMIT ? cfg_ff.rdt_hi : 8'h00;
    end else if (hit(i_paddr, `ITC_IDX_RDT_MID)) begin
      nxt_prdata[7:0] = MAX_DS_LIMIT ? cfg_ff.rdt_mid : 8'h00;
    end else if (hit(i_paddr, `ITC_IDX_RDT_LO)) begin
      nxt_prdata[7:0] = MAX_DS_LIMIT ? cfg_ff.rdt_lo : 8'h00;
    end else if (hit(i_paddr, `ITC_IDX_ID6)) begin
      nxt_prdata[7:0] = cfg_ff.maker_id[14:7];
    end else if (hit(i_paddr, `ITC_IDX_ID5)) begin
      nxt_prdata[7:0] = {cfg_ff.maker_id[6:0], 1'b0};
    end else if (hit(i_paddr, `ITC_IDX_ID4)) begin
      nxt_prdata[7:0] = cfg_ff.part_id[15:8];
    end else if (hit(i_paddr, `ITC_IDX_ID3)) begin
      nxt_prdata[7:0] = cfg_ff.part_id[7:0];
    end else if (hit(i_paddr, `ITC_IDX_ID2)) begin
      nxt_prdata[7:0] = {cfg_ff.inst_id, cfg_ff.extra_id[11:8]};
    end else if (hit(i_paddr, `ITC_IDX_ID1)) begin
      nxt_prdata[7:0] = cfg_ff.extra_id[7:0];
    end else if (hit(i_paddr, `ITC_IDX_FBA)) begin
      nxt_prdata[7:0] = {1'b0, cfg_ff.fixed_addr};
    end else if (hit(i_paddr, `ITC_IDX_CAP1)) begin
      nxt_prdata[7:0] = cap1;
    end else if (hit(i_paddr, `ITC_IDX_CAP2)) begin
      nxt_prdata[7:0] = cap2;
    end else if (hit(i_paddr, `ITC_IDX_CAP3)) begin
      nxt_prdata[7:0] = cap3;
    end else if (hit(i_paddr, `ITC_IDX_OSC)) begin
      nxt_prdata[7:0] = cfg_ff.osc_tol;
    end else if (hit(i_paddr, `ITC_IDX_RXQ)) begin
      // Empty queue reads as zero without touching pointers
      nxt_prdata[7:0] = (rx_cnt_ff != 10'h000) ? rx_mem[rx_rd_ff] : 8'h00;
    end else if (hit(i_paddr, `ITC_IDX_TXQ)) begin
      nxt_prdata[0] = (tx_cnt_ff == 10'h000);
    end else if (hit(i_paddr, `ITC_IDX_SRST)) begin
      nxt_prdata[4:0] = srst_ff;
    end else begin
      nxt_err = 1'b1;
    end
  end

  // Bus phase, ready, read data and error
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_ff <= ITC_ST_IDLE;
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      unique case (st_ff)
        ITC_ST_IDLE: begin
          if (i_psel && i_penable) begin
            st_ff <= ITC_ST_ACK;
            o_pready <= 1'b1;
            o_prdata <= i_pwrite ? 32'h0000_0000 : nxt_prdata;
            o_pslverr <= nxt_err;
          end
        end
        ITC_ST_ACK: begin
          st_ff <= ITC_ST_IDLE;
          o_pready <= 1'b0;
          o_pslverr <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  assign regs_clr = srst_ff[`ITC_SRST_REGS] || srst_ff[`ITC_SRST_WHOLE];

  // Writes land on the completing edge; a register reset wins
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || regs_clr) begin
      cfg_ff <= cfg_rst();
    end else if (wr_acc) begin
      if (MAX_DS_LIMIT && hit(i_paddr, `ITC_IDX_RDT_HI)) begin
        cfg_ff.rdt_hi <= i_pwdata[7:0];
      end
      if (MAX_DS_LIMIT && hit(i_paddr, `ITC_IDX_RDT_MID)) begin
        cfg_ff.rdt_mid <= i_pwdata[7:0];
      end
      if (MAX_DS_LIMIT && hit(i_paddr, `ITC_IDX_RDT_LO)) begin
        cfg_ff.rdt_lo <= i_pwdata[7:0];
      end
      if (hit(i_paddr, `ITC_IDX_ID6)) begin
        cfg_ff.maker_id[14:7] <= i_pwdata[7:0];
      end
      if (hit(i_paddr, `ITC_IDX_ID5)) begin
        cfg_ff.maker_id[6:0] <= i_pwdata[7:1];
      end
      if (hit(i_paddr, `ITC_IDX_ID4)) begin
        cfg_ff.part_id[15:8] <= i_pwdata[7:0];
      end
      if (hit(i_paddr, `ITC_IDX_ID3)) begin
        cfg_ff.part_id[7:0] <= i_pwdata[7:0];
      end
      if (hit(i_paddr, `ITC_IDX_ID2)) begin
        cfg_ff.inst_id <= i_pwdata[7:4];
        cfg_ff.extra_id[11:8] <= i_pwdata[3:0];
      end
      if (hit(i_paddr, `ITC_IDX_ID1)) begin
        cfg_ff.extra_id[7:0] <= i_pwdata[7:0];
      end
      if (hit(i_paddr, `ITC_IDX_FBA)) begin
        cfg_ff.fixed_addr <= i_pwdata[6:0];
      end
      if (hit(i_paddr, `ITC_IDX_OSC)) begin
        cfg_ff.osc_tol <= i_pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Soft reset control
  // ----------------------------------------------------------------
  // Bits live for exactly one cycle, so a read after the write sees zero
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      srst_ff <= 5'h00;
    end else if (wr_acc && hit(i_paddr, `ITC_IDX_SRST)) begin
      srst_ff <= i_pwdata[4:0];
    end else begin
      srst_ff <= 5'h00;
    end
  end

  // Engine-state and whole-core requests for logic outside this slice
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_engine_rst <= 1'b0;
      o_whole_rst <= 1'b0;
    end else begin
      o_engine_rst <= srst_ff[`ITC_SRST_ENGINE];
      o_whole_rst <= srst_ff[`ITC_SRST_WHOLE];
    end
  end

  assign o_cfg = cfg_ff;

  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  // Strobes are sampled with the same depth as the link clock, so the
  // byte seen at a detected edge is the one launched before it.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      lclk_s1_ff <= 1'b0;
      lclk_s2_ff <= 1'b0;
      lclk_s3_ff <= 1'b0;
      rxv_s1_ff <= 1'b0;
      rxv_s2_ff <= 1'b0;
      rxd_s1_ff <= 8'h00;
      rxd_s2_ff <= 8'h00;
      take_s1_ff <= 1'b0;
      take_s2_ff <= 1'b0;
    end else begin
      lclk_s1_ff <= i_link_clk;
      lclk_s2_ff <= lclk_s1_ff;
      lclk_s3_ff <= lclk_s2_ff;
      rxv_s1_ff <= i_rx_valid;
      rxv_s2_ff <= rxv_s1_ff;
      rxd_s1_ff <= i_rx_data;
      rxd_s2_ff <= rxd_s1_ff;
      take_s1_ff <= i_tx_take;
      take_s2_ff <= take_s1_ff;
    end
  end

  assign link_edge = lclk_s2_ff && !lclk_s3_ff;

  // ----------------------------------------------------------------
  // Queues
  // ----------------------------------------------------------------
  assign rx_clr = srst_ff[`ITC_SRST_RXQ] || srst_ff[`ITC_SRST_ENGINE]
    || srst_ff[`ITC_SRST_WHOLE];
  assign tx_clr = srst_ff[`ITC_SRST_TXQ] || srst_ff[`ITC_SRST_ENGINE]
    || srst_ff[`ITC_SRST_WHOLE];
  // Overflowing bytes are dropped; empty pops are ignored
  assign rx_push = link_edge && rxv_s2_ff && (rx_cnt_ff != `ITC_FIFO_DEPTH);
  assign rx_pop = rd_acc && hit(i_paddr, `ITC_IDX_RXQ) && (rx_cnt_ff != 10'h000);
  assign tx_push = wr_acc && hit(i_paddr, `ITC_IDX_TXQ)
    && (tx_cnt_ff != `ITC_FIFO_DEPTH);
  assign tx_pop = link_edge && take_s2_ff && (tx_cnt_ff != 10'h000);

  // Storage writes; no reset needed on the arrays
  always_ff @(posedge i_core_clk) begin
    if (rx_push) begin
      rx_mem[rx_wr_ff] <= rxd_s2_ff;
    end
    if (tx_push) begin
      tx_mem[tx_wr_ff] <= i_pwdata[7:0];
    end
  end

  // Receive pointers and level
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || rx_clr) begin
      rx_wr_ff <= '0;
      rx_rd_ff <= '0;
      rx_cnt_ff <= 10'h000;
    end else begin
      if (rx_push) begin
        rx_wr_ff <= rx_wr_ff + 9'h001;
      end
      if (rx_pop) begin
        rx_rd_ff <= rx_rd_ff + 9'h001;
      end
      if (rx_push && !rx_pop) begin
        rx_cnt_ff <= rx_cnt_ff + 10'h001;
      end else if (!rx_push && rx_pop) begin
        rx_cnt_ff <= rx_cnt_ff - 10'h001;
      end
    end
  end

  // Transmit pointers and level
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || tx_clr) begin
      tx_wr_ff <= '0;
      tx_rd_ff <= '0;
      tx_cnt_ff <= 10'h000;
    end else begin
      if (tx_push) begin
        tx_wr_ff <= tx_wr_ff + 9'h001;
      end
      if (tx_pop) begin
        tx_rd_ff <= tx_rd_ff + 9'h001;
      end
      if (tx_push && !tx_pop) begin
        tx_cnt_ff <= tx_cnt_ff + 10'h001;
      end else if (!tx_push && tx_pop) begin
        tx_cnt_ff <= tx_cnt_ff - 10'h001;
      end
    end
  end

  // Queue flags and head byte towards the engine; one cycle behind the levels
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_tx_data <= 8'h00;
      o_tx_avail <= 1'b0;
      o_tx_full <= 1'b0;
      o_rx_not_empty <= 1'b0;
      o_rx_full <= 1'b0;
    end else begin
      o_tx_data <= tx_mem[tx_rd_ff];
      o_tx_avail <= (tx_cnt_ff != 10'h000);
      o_tx_full <= (tx_cnt_ff == `ITC_FIFO_DEPTH);
      o_rx_not_empty <= (rx_cnt_ff != 10'h000);
      o_rx_full <= (rx_cnt_ff == `ITC_FIFO_DEPTH);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  chk_rx_pop_drains: assert property (
    rx_pop && !rx_push && !rx_clr |=> rx_cnt_ff == $past(rx_cnt_ff) - 10'h001)
    else $error("receive read did not remove one byte");

  chk_tx_push_queues: assert property (
    tx_push && !tx_pop && !tx_clr |=> tx_cnt_ff == $past(tx_cnt_ff) + 10'h001)
    else $error("transmit write did not queue one byte");

  chk_tx_read_flag: assert property (
    st_ff == ITC_ST_IDLE && i_psel && i_penable && !i_pwrite && hit(i_paddr, `ITC_IDX_TXQ)
    |=> o_pready && o_prdata == {31'h0, ($past(tx_cnt_ff) == 10'h000)} ##1 !o_pready)
    else $error("transmit port read wrong");

  chk_full_drop: assert property (
    tx_cnt_ff == `ITC_FIFO_DEPTH && wr_acc && hit(i_paddr, `ITC_IDX_TXQ) && !tx_pop && !tx_clr
    |=> tx_cnt_ff == `ITC_FIFO_DEPTH && $stable(tx_wr_ff))
    else $error("full transmit queue overflowed");

  chk_empty_read: assert property (
    rx_cnt_ff == 10'h000 && rd_acc && hit(i_paddr, `ITC_IDX_RXQ) && !rx_clr
    |=> $stable(rx_rd_ff))
    else $error("empty receive read moved pointer");

  chk_srst_selfclr: assert property (
    wr_acc && hit(i_paddr, `ITC_IDX_SRST) |=> srst_ff == 5'($past(i_pwdata)) ##1 srst_ff == 5'h00)
    else $error("soft reset bit did not clear itself");

  chk_regs_reset: assert property (
    srst_ff[`ITC_SRST_REGS] |=> cfg_ff == cfg_rst())
    else $error("register reset missed");

  chk_engine_flush: assert property (
    srst_ff[`ITC_SRST_ENGINE] |=> rx_cnt_ff == 10'h000 && tx_cnt_ff == 10'h000 && o_engine_rst)
    else $error("engine reset missed a queue");

  chk_queue_flush: assert property (
    srst_ff[`ITC_SRST_TXQ] && !srst_ff[`ITC_SRST_ENGINE] && !srst_ff[`ITC_SRST_WHOLE]
    && !srst_ff[`ITC_SRST_RXQ]
    |=> tx_cnt_ff == 10'h000 && rx_cnt_ff == $past(rx_cnt_ff) + 10'($past(rx_push))
      - 10'($past(rx_pop)))
    else $error("transmit flush wrong");

  chk_whole_reset: assert property (
    srst_ff[`ITC_SRST_WHOLE] |=> cfg_ff == cfg_rst() && rx_cnt_ff == 10'h000 && o_whole_rst)
    else $error("whole reset incomplete");

  chk_depth_cap: assert property (
    rx_cnt_ff <= `ITC_FIFO_DEPTH && tx_cnt_ff <= `ITC_FIFO_DEPTH)
    else $error("queue level beyond depth");

  // Checked on the bus answer, so the read path is covered too
  chk_spec_nonzero: assert property (
    st_ff == ITC_ST_IDLE && i_psel && i_penable && !i_pwrite && hit(i_paddr, `ITC_IDX_CAP2)
    |=> o_prdata[3:0] != 4'h0 && o_prdata[5:4] == 2'h0)
    else $error("capability two malformed");

endmodule

// ---- dv/itc_link_model.sv ----
// Behavioural far-side engine that strobes bytes across the link clock
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Link partner model
// ----------------------------------------------------------------
module itc_link_model (
  // Link strobes towards the register slice
  output logic o_link_clk,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_tx_take
);
  // Idle levels; the link clock stands still between frames
  initial begin
    o_link_clk = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_tx_take = 1'b0;
  end

  // One link cycle plus an idle gap; the core needs a few cycles to see the edge
  task automatic cyc(input logic v, input logic t, input logic [7:0] d);
    o_rx_valid = v;
    o_tx_take = t;
    o_rx_data = d;
    #80 o_link_clk = 1'b1;
    #80 o_link_clk = 1'b0;
    o_rx_valid = 1'b0;
    o_tx_take = 1'b0;
    // Released data flips so a stale byte can never pass for a fresh one
    o_rx_data = ~d;
    #80;
  endtask

  // Hand one received byte to the slice
  task automatic push(input logic [7:0] d);
    cyc(1'b1, 1'b0, d);
  endtask

  // Consume the transmit head byte
  task automatic take();
    cyc(1'b0, 1'b1, ~o_rx_data);
  endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the identity, capability, queue port and soft reset registers
`timescale 1ns/1ps
`include "itc_consts.svh"

module tb import itc_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0; // Core clock, 20 ns
  logic rst = 1'b1; // Synchronous reset
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, lclk, rxv, txt, txa, txf, rxne, rxf, eng, whl;
  logic [7:0] rxd, txd;
  itc_cfg_t cfg; // Configuration image seen by the engine
  int n_errors = 0;
  int tests_run = 0;
  int n_eng = 0; // Engine reset pulses seen
  int n_whl = 0; // Whole-core reset pulses seen
  // Ordinary register cases: index, reset value, write data, read-back
  typedef struct packed {
    logic [5:0] idx;
    logic [7:0] rv;
    logic [7:0] wd;
    logic [7:0] ex;
  } itc_row_t;
  itc_row_t rows[14] = '{
    '{`ITC_IDX_RDT_HI, 8'h00, 8'hA5, 8'hA5},
    '{`ITC_IDX_RDT_MID, 8'h00, 8'h5A, 8'h5A},
    '{`ITC_IDX_RDT_LO, 8'h00, 8'h3C, 8'h3C},
    '{`ITC_IDX_ID6, 8'h02, 8'hC3, 8'hC3},
    '{`ITC_IDX_ID5, 8'hAA, 8'hFF, 8'hFE},
    '{`ITC_IDX_ID4, 8'h00, 8'h12, 8'h12},
    '{`ITC_IDX_ID3, 8'hA5, 8'h34, 8'h34},
    '{`ITC_IDX_ID2, 8'h20, 8'h9B, 8'h9B},
    '{`ITC_IDX_ID1, 8'h00, 8'h7C, 8'h7C},
    '{`ITC_IDX_FBA, 8'h08, 8'hFF, 8'h7F},
    '{`ITC_IDX_CAP1, 8'h01, 8'hFF, 8'h01},
    '{`ITC_IDX_CAP2, 8'hC2, 8'h00, 8'hC2},
    '{`ITC_IDX_CAP3, 8'h40, 8'hFF, 8'h40},
    '{`ITC_IDX_OSC, 8'h00, 8'hFF, 8'hFF}
  };

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  always #10 clk = ~clk;

  // HDR and pending-read options on, so the capability bits read one
  itc_regbank #(.HDR_CAP(1'b1), .IBI_MDB_CAP(1'b1)) dut (.i_core_clk(clk), .i_sys_rst(rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_link_clk(lclk),
    .i_rx_valid(rxv), .i_rx_data(rxd), .i_tx_take(txt), .o_tx_data(txd), .o_tx_avail(txa),
    .o_tx_full(txf), .o_rx_not_empty(rxne), .o_rx_full(rxf), .o_cfg(cfg),
    .o_engine_rst(eng), .o_whole_rst(whl));

  itc_link_model lnk (.o_link_clk(lclk), .o_rx_valid(rxv), .o_rx_data(rxd), .o_tx_take(txt));

  // Count reset request pulses; they last one cycle only
  always @(posedge clk) begin
    if (eng === 1'b1) n_eng++;
    if (whl === 1'b1) n_whl++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("counts: %0d checks, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [95:0] e, input logic [95:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
      n_errors++;
    end
  endtask

  // One bus transfer; an idle edge follows so strobes never toggle twice in a step
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [32:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = {pslverr, prdata};
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [32:0] r;
    apb(1'b1, idx, wd, r);
  endtask

  // Read and compare error flag plus the whole data word
  task automatic rdc(input string n, input logic [5:0] idx, input logic [7:0] e,
                     input logic ee = 1'b0);
    logic [32:0] r;
    apb(1'b0, idx, 8'h00, r);
    chk(n, {ee, 24'h000000, e}, r);
  endtask

  // Let registered flags settle after an action
  task automatic st();
    repeat (3) @(posedge clk);
  endtask

  // Bounded wait for received data, as software would poll the flag
  task automatic wait_rx();
    int n;
    n = 0;
    while (rxne !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("rx not empty", 1, rxne);
    // A wait that ran out has already counted its mismatch
    if (rxne !== 1'b1) tally_and_finish();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    st();
    // Reset values, write masks and read-only bits
    foreach (rows[i]) begin
      rdc("reset value", rows[i].idx, rows[i].rv);
      wr(rows[i].idx, rows[i].wd);
      rdc("read back", rows[i].idx, rows[i].ex);
    end
    chk("cfg", {8'hA5, 8'h5A, 8'h3C, 15'h61FF, 16'h1234, 4'h9, 12'hB7C, 7'h7F, 8'hFF}, cfg);
    rdc("unmapped", 6'h1B, 8'h00, 1'b1);
    $display("test registers done");
    // Receive port drains in order; an empty read must not disturb pointers
    for (int k = 1; k <= 3; k++) lnk.push(8'(k * 8'h11));
    wait_rx();
    for (int k = 1; k <= 3; k++) rdc("rx pop", `ITC_IDX_RXQ, 8'(k * 8'h11));
    st();
    chk("rx drained", 0, rxne);
    rdc("rx underrun", `ITC_IDX_RXQ, 8'h00);
    lnk.push(8'h44);
    wait_rx();
    rdc("rx after underrun", `ITC_IDX_RXQ, 8'h44);
    $display("test receive done");
    // Transmit port: fill past capacity, then drain in order from the far side
    rdc("tx empty", `ITC_IDX_TXQ, 8'h01);
    for (int k = 0; k < 512; k++) wr(`ITC_IDX_TXQ, 8'(k));
    wr(`ITC_IDX_TXQ, 8'hEE);
    st();
    chk("tx full", 1, txf);
    rdc("tx not empty", `ITC_IDX_TXQ, 8'h00);
    for (int k = 0; k < 512; k++) begin
      chk("tx head", {1'b1, 8'(k)}, {txa, txd});
      lnk.take();
    end
    chk("tx overflow dropped", 0, txa);
    $display("test transmit done");
    // Receive queue fills to its depth; the surplus byte is dropped
    for (int k = 0; k < 513; k++) lnk.push(8'(k));
    chk("rx full", 1, rxf);
    // Queue flushes keep the other queue
    lnk.push(8'h5C);
    wr(`ITC_IDX_TXQ, 8'h77);
    wr(`ITC_IDX_SRST, 8'h02);
    st();
    chk("rx flush", {1'b0, 1'b1}, {rxne, txa});
    rdc("self clear", `ITC_IDX_SRST, 8'h00);
    wr(`ITC_IDX_SRST, 8'h04);
    st();
    rdc("tx flush", `ITC_IDX_TXQ, 8'h01);
    // Engine reset empties queues, keeps configuration
    lnk.push(8'h5C);
    wr(`ITC_IDX_TXQ, 8'h77);
    wr(`ITC_IDX_SRST, 8'h08);
    st();
    chk("engine reset", {1'b0, 1'b0, 8'hFF, 32'd1, 32'd0}, {rxne, txa, cfg.osc_tol, n_eng, n_whl});
    // Register-only reset leaves queues alone
    wr(`ITC_IDX_TXQ, 8'h77);
    wr(`ITC_IDX_SRST, 8'h10);
    st();
    chk("register reset", {1'b1, 8'h00, 7'h08}, {txa, cfg.osc_tol, cfg.fixed_addr});
    rdc("self clear", `ITC_IDX_SRST, 8'h00);
    // Whole-core reset clears everything
    wr(`ITC_IDX_OSC, 8'hFF);
    wr(`ITC_IDX_SRST, 8'h01);
    st();
    chk("whole reset", {1'b0, 8'h00, 32'd1}, {txa, cfg.osc_tol, n_whl});
    $display("test soft reset done");
    // Hard reset in mid-run
    wr(`ITC_IDX_OSC, 8'hFF);
    wr(`ITC_IDX_TXQ, 8'h55);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    st();
    chk("hard reset", {1'b0, 8'h00, 7'h08}, {txa, cfg.osc_tol, cfg.fixed_addr});
    $display("test hard reset done");
    tally_and_finish();
  end
endmodule
